//--- crt_edc_step.sv
`timescale 1ns/100ps
module crt_edc_step
   import crt_pkg::*;
(
   input  wire crt_edc_t   mode,
   input  wire logic [7:0] sumIn,
   input  wire logic [7:0] dataIn,
   output logic      [7:0] sumOut
);

   // one byte of check code per call; both codes leave a zero residue over data plus check
   always_comb begin
      logic [7:0] c;
      c = sumIn ^ dataIn;
      // RULE16 msb-first crc8
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ CRC8_POLY) : {c[6:0], 1'b0};
      end
      // RULE14 scheme chosen per frame
      case (mode)
         EDC_CRC8: sumOut = c;
         EDC_LRC8: sumOut = sumIn ^ dataIn;
         default:  sumOut = CRC8_INIT;
      endcase
   end

endmodule // crt_edc_step

//--- crt_framer.sv
`timescale 1ns/100ps
module crt_framer
   import crt_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic [7:0]     nodeAddr,
   input  wire crt_edc_t       edcMode,
   input  wire logic [3:0]     preLen,
   input  wire logic [7:0]     ipgCycles,
   input  wire logic           txStart,
   input  wire crt_header_t    txHdr,
   input  wire logic [15:0]    txPayLen,
   input  wire logic [7:0]     txPayData,
   input  wire logic           txPayValid,
   output logic                txPayReady,
   output logic                txBusy,
   output logic                txUnderrun,
   output logic                phyTxValid,
   output logic [7:0]          phyTxData,
   input  wire logic           phyRxValid,
   input  wire logic [7:0]     phyRxData,
   output crt_header_t         rxHdr,
   output logic                rxHdrValid,
   output logic [7:0]          rxPayData,
   output logic                rxPayValid,
   output logic                rxDone,
   output crt_rx_result_t      rxRes
);

   // RULE1 destination hit: own address or broadcast
   function automatic logic addrHit(input logic [7:0] da, input logic [7:0] node);
      addrHit = (da == node) || (da == ADDR_BCAST);
   endfunction

   crt_tx_state_t  txState_q, txState_d;
   logic [15:0]    txCnt_q, txLen_q;
   crt_header_t    txHdrL_q;
   crt_edc_t       txMode_q;
   logic [3:0]     txPre_q, preLenC;
   logic [7:0]     txCrc_q, txCrcNext, txByte;
   logic           txPayReady_q, txBusy_q, txUnderrun_q, phyTxValid_q;
   logic [7:0]     phyTxData_q;

   // preamble length clamped to 1..8 bytes including the delimiter
   assign preLenC = (preLen < PRE_LEN_MIN) ? PRE_LEN_MIN :
                    (preLen > PRE_LEN_MAX) ? PRE_LEN_MAX : preLen;

   // transmit sequencing
   always_comb begin
      txState_d = txState_q;
      case (txState_q)
         TX_IDLE: begin
            // RULE10 single-byte preamble goes straight to the delimiter
            if (txStart) txState_d = (preLenC > PRE_LEN_MIN) ? TX_PRE : TX_SFD;
         end
         TX_PRE: begin
            if (txCnt_q[3:0] == txPre_q - 4'h2) txState_d = TX_SFD;
         end
         TX_SFD:  txState_d = TX_HDR;
         // RULE15 header, payload, check
         TX_HDR: begin
            if (txCnt_q == {13'h0000, HDR_LAST_IDX}) begin
               if (txLen_q != 16'h0000) txState_d = TX_PAY;
               else txState_d = (txMode_q != EDC_NONE) ? TX_FCS : TX_GAP;
            end
         end
         TX_PAY: begin
            if (txCnt_q == txLen_q - 16'h0001) begin
               txState_d = (txMode_q != EDC_NONE) ? TX_FCS : TX_GAP;
            end
         end
         TX_FCS:  txState_d = TX_GAP;
         // RULE17 idle gap before the next start is allowed
         TX_GAP: begin
            if (txCnt_q >= {8'h00, ipgCycles}) txState_d = TX_IDLE;
         end
         default: txState_d = TX_IDLE;
      endcase
   end

   // state and shared byte counter; counter restarts on every state change
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txState_q <= TX_IDLE;
         txCnt_q   <= 16'h0000;
      end else begin
         txState_q <= txState_d;
         txCnt_q   <= (txState_d != txState_q) ? 16'h0000 : 16'(txCnt_q + 16'h0001);
      end
   end

   // header, length, check mode and preamble length held for the whole frame; nodeAddr and ipgCycles are still read live
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txHdrL_q <= '0;
         txLen_q  <= 16'h0000;
         txMode_q <= EDC_CRC8;
         txPre_q  <= PRE_LEN_MIN;
      end else if (txState_q == TX_IDLE && txStart) begin
         txHdrL_q <= txHdr;
         txLen_q  <= txPayLen;
         txMode_q <= edcMode;
         txPre_q  <= preLenC;
      end
   end

   // byte of the current cycle; the source field always carries our own address
   always_comb begin
      case (txCnt_q[1:0])
         // RULE1 destination byte as given
         2'h0:    txByte = txHdrL_q.dstAddr;
         // RULE2 RULE3 one-byte source from the node address
         2'h1:    txByte = nodeAddr;
         // RULE4 message kind
         2'h2:    txByte = txHdrL_q.msgType;
         // RULE5 RULE6 RULE7 RULE8 RULE9 packed status byte
         default: txByte = txHdrL_q.status;
      endcase
      if (txState_q == TX_PAY) txByte = txPayValid ? txPayData : 8'h00;
   end

   crt_edc_step txEdc (
      .mode   (txMode_q),
      .sumIn  (txCrc_q),
      .dataIn (txByte),
      .sumOut (txCrcNext)
   );

   // phy-side byte stream, registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phyTxValid_q <= 1'b0;
         phyTxData_q  <= 8'h00;
         txCrc_q      <= CRC8_INIT;
         txUnderrun_q <= 1'b0;
      end else begin
         phyTxValid_q <= 1'b1;
         txUnderrun_q <= 1'b0;
         case (txState_q)
            TX_PRE: phyTxData_q <= PREAMBLE_BYTE;
            TX_SFD: begin
               phyTxData_q <= SFD_BYTE;
               txCrc_q     <= CRC8_INIT;
            end
            // RULE11 no padding: only header and given payload are sent
            TX_HDR, TX_PAY: begin
               phyTxData_q  <= txByte;
               txCrc_q      <= txCrcNext;
               txUnderrun_q <= (txState_q == TX_PAY) && !txPayValid;
            end
            // RULE13 trailing check byte
            TX_FCS: phyTxData_q <= txCrc_q;
            default: begin
               phyTxValid_q <= 1'b0;
               phyTxData_q  <= 8'h00;
            end
         endcase
      end
   end

   // ready mirrors the payload state one edge ahead so it lines up with the byte taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txPayReady_q <= 1'b0;
         txBusy_q     <= 1'b0;
      end else begin
         txPayReady_q <= (txState_d == TX_PAY);
         txBusy_q     <= (txState_d != TX_IDLE);
      end
   end

   // receive: phy pins pass two flops before use
   logic          rxV1_q, rxV2_q, rxJunk_q;
   logic [7:0]    rxD1_q, rxD2_q, rxCrc_q, rxCrcNext, rxHold_q, rxPayData_q;
   logic          rxHoldV_q, rxPayValid_q, rxHdrValid_q, rxDone_q;
   logic [2:0]    rxCnt_q;
   crt_edc_t      rxMode_q;
   crt_rx_state_t rxState_q, rxState_d;
   crt_header_t   rxHdr_q;
   crt_rx_result_t rxRes_q;
   logic          rxHit;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxV1_q <= 1'b0;
         rxV2_q <= 1'b0;
         rxD1_q <= 8'h00;
         rxD2_q <= 8'h00;
      end else begin
         rxV1_q <= phyRxValid;
         rxV2_q <= rxV1_q;
         rxD1_q <= phyRxData;
         rxD2_q <= rxD1_q;
      end
   end

   assign rxHit = addrHit(rxHdr_q.dstAddr, nodeAddr);

   always_comb begin
      rxState_d = rxState_q;
      case (rxState_q)
         // RULE10 any preamble length, even none, before the delimiter
         RX_HUNT: if (rxV2_q && !rxJunk_q && rxD2_q == SFD_BYTE) rxState_d = RX_HDR;
         RX_HDR: begin
            if (!rxV2_q) rxState_d = RX_HUNT;
            else if (rxCnt_q == HDR_LAST_IDX) rxState_d = RX_BODY;
         end
         // RULE12 body runs until the carrier drops, with no length cap
         RX_BODY: if (!rxV2_q) rxState_d = RX_HUNT;
         default: rxState_d = RX_HUNT;
      endcase
   end

   // junk ahead of the delimiter spoils the frame, so a data byte cannot fake a start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxState_q <= RX_HUNT;
         rxCnt_q   <= 3'h0;
         rxJunk_q  <= 1'b0;
      end else begin
         rxState_q <= rxState_d;
         rxCnt_q   <= (rxState_d != rxState_q) ? 3'h0 : 3'(rxCnt_q + 3'h1);
         if (!rxV2_q) rxJunk_q <= 1'b0;
         else if (rxState_q == RX_HUNT && rxD2_q != PREAMBLE_BYTE && rxD2_q != SFD_BYTE)
            rxJunk_q <= 1'b1;
         else if (rxState_q != RX_HUNT) rxJunk_q <= 1'b1;
      end
   end

   crt_edc_step rxEdc (
      .mode   (rxMode_q),
      .sumIn  (rxCrc_q),
      .dataIn (rxD2_q),
      .sumOut (rxCrcNext)
   );

   // header capture and end-of-frame verdict
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxHdr_q      <= '0;
         rxHdrValid_q <= 1'b0;
         rxDone_q     <= 1'b0;
         rxRes_q      <= '0;
         rxMode_q     <= EDC_CRC8;
      end else begin
         rxHdrValid_q <= 1'b0;
         rxDone_q     <= 1'b0;
         if (rxState_q == RX_HUNT && rxState_d == RX_HDR) rxMode_q <= edcMode;
         if (rxState_q == RX_HDR && rxV2_q) begin
            case (rxCnt_q[1:0])
               2'h0:    rxHdr_q.dstAddr <= rxD2_q;
               2'h1:    rxHdr_q.srcAddr <= rxD2_q;
               2'h2:    rxHdr_q.msgType <= crt_msg_t'(rxD2_q);
               default: rxHdr_q.status  <= crt_status_t'(rxD2_q);
            endcase
            rxHdrValid_q <= (rxCnt_q == HDR_LAST_IDX);
         end
         // RULE11 fewer than four bytes is the only length fault
         if (rxState_q == RX_HDR && !rxV2_q) begin
            rxDone_q <= 1'b1;
            rxRes_q  <= '{forMe: 1'b0, shortFrame: 1'b1, checkBad: 1'b0,
                          badSource: 1'b0, badCode: 1'b0};
         end
         if (rxState_q == RX_BODY && !rxV2_q) begin
            rxDone_q          <= 1'b1;
            rxRes_q.forMe      <= rxHit;
            rxRes_q.shortFrame <= 1'b0;
            // RULE13 RULE14 zero residue over data and check byte
            rxRes_q.checkBad   <= (rxMode_q != EDC_NONE) &&
                                  (!rxHoldV_q || rxCrc_q != CHECK_RESIDUE);
            // RULE2 broadcast is no valid source
            rxRes_q.badSource  <= (rxHdr_q.srcAddr == ADDR_BCAST);
            // RULE4 RULE9 unknown kind or state
            rxRes_q.badCode    <= (rxHdr_q.msgType >= MSG_KINDS) ||
                                  (rxHdr_q.status.nodeState >= STATE_KINDS);
         end
      end
   end

   // payload is held back one byte so the check byte never reaches the user
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxCrc_q      <= CRC8_INIT;
         rxHold_q     <= 8'h00;
         rxHoldV_q    <= 1'b0;
         rxPayData_q  <= 8'h00;
         rxPayValid_q <= 1'b0;
      end else begin
         rxPayValid_q <= 1'b0;
         if (rxState_q == RX_HUNT) begin
            rxCrc_q   <= CRC8_INIT;
            rxHoldV_q <= 1'b0;
         end else if (rxV2_q) begin
            rxCrc_q <= rxCrcNext;
            if (rxState_q == RX_BODY) begin
               rxHold_q     <= rxD2_q;
               rxHoldV_q    <= 1'b1;
               rxPayData_q  <= rxHold_q;
               rxPayValid_q <= rxHoldV_q && rxHit;
            end
         end else if (rxState_q == RX_BODY) begin
            // without a check the held byte is payload
            rxPayData_q  <= rxHold_q;
            rxPayValid_q <= rxHoldV_q && rxHit && (rxMode_q == EDC_NONE);
         end
      end
   end

   assign txPayReady = txPayReady_q;
   assign txBusy     = txBusy_q;
   assign txUnderrun = txUnderrun_q;
   assign phyTxValid = phyTxValid_q;
   assign phyTxData  = phyTxData_q;
   assign rxHdr      = rxHdr_q;
   assign rxHdrValid = rxHdrValid_q;
   assign rxPayData  = rxPayData_q;
   assign rxPayValid = rxPayValid_q;
   assign rxDone     = rxDone_q;
   assign rxRes      = rxRes_q;

   // checks; gap counter saturates and starts high so the first frame passes
   logic [7:0] gapLow_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) gapLow_q <= 8'hff;
      else if (phyTxValid_q) gapLow_q <= 8'h00;
      else if (gapLow_q != 8'hff) gapLow_q <= 8'(gapLow_q + 8'h01);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seqSfdOut;
      // count pinned to zero so a header byte equal to the delimiter cannot fake a start
      phyTxValid_q && (phyTxData_q == SFD_BYTE) && (txState_q == TX_HDR) &&
      (txCnt_q == 16'h0000);
   endsequence
   sequence seqHdrOut;
      phyTxValid_q [*4];
   endsequence

   chk_tx_hdr_order: // RULE15 RULE11
   assert property (seqSfdOut |=> seqHdrOut) else $error("header did not follow delimiter");
   chk_tx_src_addr: // RULE2 RULE3
   assert property (seqSfdOut |=> ##1 (phyTxData_q == $past(nodeAddr)))
      else $error("source byte is not node address");
   chk_tx_status_byte: // RULE5 RULE6 RULE7 RULE8 RULE9
   assert property (seqSfdOut |=> ##3 (phyTxData_q == txHdrL_q.status))
      else $error("status byte mismatch");
   chk_tx_preamble: // RULE10
   assert property ($rose(phyTxValid_q) |->
      phyTxData_q == ((txPre_q <= PRE_LEN_MIN) ? SFD_BYTE : PREAMBLE_BYTE))
      else $error("wrong first byte");
   chk_tx_gap_min: // RULE17
   assert property ($rose(phyTxValid_q) |-> gapLow_q >= ipgCycles) else $error("gap too short");
   chk_tx_fcs_byte: // RULE13 RULE16
   assert property (txState_q == TX_FCS |=> phyTxValid_q && phyTxData_q == $past(txCrc_q))
      else $error("check byte mismatch");
   chk_rx_short_pre: // RULE10
   assert property (rxState_q == RX_HUNT && rxV2_q && !rxJunk_q && rxD2_q == SFD_BYTE
      |=> rxState_q == RX_HDR) else $error("delimiter not accepted");
   chk_rx_no_max: // RULE12
   assert property (rxState_q == RX_BODY && rxV2_q |=> rxState_q == RX_BODY)
      else $error("long frame cut");
   chk_rx_addr_hit: // RULE1
   assert property (rxDone_q && !rxRes_q.shortFrame |-> rxRes_q.forMe == rxHit)
      else $error("address match wrong");

endmodule // crt_framer

//--- crt_peer_model.sv
`timescale 1ns/100ps
module crt_peer_model
   import crt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       phyTxValid,
   input  wire logic [7:0] phyTxData,
   output logic            phyRxValid,
   output logic [7:0]      phyRxData
);
   logic [7:0] txCap [$];        // bytes seen from the framer
   logic [7:0] rxBuf [0:2047];   // body of the next frame to send
   logic [7:0] byteQ  = 8'h00;
   logic [7:0] idleQ  = 8'ha7;
   int         idleRun = 0;
   int         lastGap = 0;
   logic       prevTx  = 1'b0;

   // idle line never repeats the last byte, so stale data cannot pass
   assign phyRxData = phyRxValid ? byteQ : idleQ;
   initial phyRxValid = 1'b0;
   always @(posedge clk) idleQ <= idleQ + 8'h3b;

   always @(posedge clk) begin
      if (phyTxValid) txCap.push_back(phyTxData);
      if (phyTxValid && !prevTx) lastGap = idleRun;
      idleRun = phyTxValid ? 0 : idleRun + 1;
      prevTx = phyTxValid;
   end

   function automatic logic [7:0] edcStep(crt_edc_t m, logic [7:0] s, logic [7:0] d);
      logic [7:0] c;
      c = s ^ d;
      if (m == EDC_LRC8) return c;
      for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      return (m == EDC_CRC8) ? c : s;
   endfunction

   task automatic send(input int n, input int pre, input crt_edc_t m, input logic bad);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < n + pre + int'(m != EDC_NONE); i++) begin
         @(posedge clk);
         phyRxValid <= 1'b1;
         if (i < pre - 1) byteQ <= 8'h55;
         else if (i == pre - 1) byteQ <= 8'hd5;
         else if (i < pre + n) begin
            byteQ <= rxBuf[i - pre];
            s = edcStep(m, s, rxBuf[i - pre]);
         end
         else byteQ <= s ^ {7'h00, bad};
      end
      @(posedge clk);
      phyRxValid <= 1'b0;
   endtask
endmodule // crt_peer_model

//--- crt_pkg.sv
// Operation
// (RULE1) A destination byte of 0 names the master, 1 to 254 name one slave and 255 names every node.
// (RULE2) The source byte is 0 from the master and 1 to 254 from a slave, and 255 is never a valid source.
// (RULE3) Every node address is one byte, so destination and source take one byte each.
// (RULE4) The type byte selects one of ten message kinds, from discovery to reconnect.
// (RULE5) Status bit 0 is clear while more frames follow and set on the final frame.
// (RULE6) Status bit 1 is clear while the operation is pending and set once it is done.
// (RULE7) Status bit 2 is set by the sender to report an error and clear otherwise.
// (RULE8) Status bit 3 is set to announce a protocol state change in the next cycle.
// (RULE9) Status bits 7:4 carry the node state, 0 discovery up to 7 reset.
// (RULE10) The sender can shorten the preamble to one byte and the receiver accepts that.
// (RULE11) Frames as short as four bytes pass without rejection or padding.
// (RULE12) The receiver sets no upper limit on frame length.
// (RULE13) By default the frame ends in an 8-bit CRC made by the sender and checked by the receiver.
// (RULE14) The check scheme can be switched at run time to another code.
// (RULE15) After the preamble come destination, source, type, status, payload and then the check.
// (RULE16) The default check uses polynomial x^8+x^2+x+1 starting from zero.
// (RULE17) The sender keeps a configurable idle gap of at least 260 ns between frames; the code takes ipgCycles as given, with no floor at IPG_MIN_CYC.
package crt_pkg;

   // address encodings
   localparam logic [7:0] ADDR_MASTER   = 8'h00;
   localparam logic [7:0] ADDR_BCAST    = 8'hff;

   // preamble and start-of-frame delimiter
   localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE      = 8'hd5;
   localparam logic [3:0] PRE_LEN_MIN   = 4'h1;
   localparam logic [3:0] PRE_LEN_MAX   = 4'h8;

   // check code
   localparam logic [7:0] CRC8_POLY     = 8'h07;
   localparam logic [7:0] CRC8_INIT     = 8'h00;
   localparam logic [7:0] CHECK_RESIDUE = 8'h00;

   // header layout: four bytes, index of the last one
   localparam logic [2:0] HDR_LAST_IDX  = 3'h3;
   localparam logic [7:0] MSG_KINDS     = 8'h0a;
   localparam logic [3:0] STATE_KINDS   = 4'h8;

   // inter-frame gap
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         IPG_MIN_NS    = 260;
   localparam logic [7:0] IPG_MIN_CYC   =
      8'((IPG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      EDC_NONE = 2'b00,
      EDC_CRC8 = 2'b01,
      EDC_LRC8 = 2'b10
   } crt_edc_t;

   typedef enum logic [7:0] {
      MSG_DISCOVERY_MULTICAST = 8'h00,
      MSG_PARAMETER_MULTICAST = 8'h01,
      MSG_SYNC_MULTICAST      = 8'h02,
      MSG_LINE_DELAY_REQUEST  = 8'h03,
      MSG_LINE_DELAY_RESPONSE = 8'h04,
      MSG_OUTPUT_MULTICAST    = 8'h05,
      MSG_INPUT_UNICAST       = 8'h06,
      MSG_ALARM_UNICAST       = 8'h07,
      MSG_DIAGNOSTIC_UNICAST  = 8'h08,
      MSG_RECONNECT_UNICAST   = 8'h09
   } crt_msg_t;

   typedef enum logic [3:0] {
      STATE_DISCOVERY   = 4'h0,
      STATE_PARAMETERIZE = 4'h1,
      STATE_SYNC        = 4'h2,
      STATE_IO_EXCHANGE = 4'h3,
      STATE_ALARM       = 4'h4,
      STATE_DIAGNOSTIC  = 4'h5,
      STATE_RECONNECT   = 4'h6,
      STATE_RESET       = 4'h7
   } crt_state_t;

   // status byte, bit 7 first
   typedef struct packed {
      crt_state_t nodeState;
      logic       stateChange;
      logic       error;
      logic       done;
      logic       last;
   } crt_status_t;

   typedef struct packed {
      logic [7:0]  dstAddr;
      logic [7:0]  srcAddr;
      crt_msg_t    msgType;
      crt_status_t status;
   } crt_header_t;

   typedef struct packed {
      logic forMe;
      logic shortFrame;
      logic checkBad;
      logic badSource;
      logic badCode;
   } crt_rx_result_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_PRE  = 3'b001,
      TX_SFD  = 3'b010,
      TX_HDR  = 3'b011,
      TX_PAY  = 3'b100,
      TX_FCS  = 3'b101,
      TX_GAP  = 3'b110
   } crt_tx_state_t;

   typedef enum logic [1:0] {
      RX_HUNT = 2'b00,
      RX_HDR  = 2'b01,
      RX_BODY = 2'b10
   } crt_rx_state_t;

endpackage

//--- test_compact_rt_ethernet_framer.sv
`timescale 1ns/100ps
module test_compact_rt_ethernet_framer;
   import crt_pkg::*;
   logic           clk, rst, txStart, txPayValid, txPayReady, txBusy, txUnderrun;
   logic [7:0]     nodeAddr, ipgCycles, txPayData, phyTxData, phyRxData, rxPayData;
   crt_edc_t       edcMode;
   logic [3:0]     preLen;
   crt_header_t    txHdr, rxHdr;
   logic [15:0]    txPayLen;
   logic           phyTxValid, phyRxValid, rxHdrValid, rxPayValid, rxDone;
   crt_rx_result_t rxRes, resQ;
   logic [7:0]     pay [0:2047];
   int             n_mismatch, samples_checked, cycles, pIdx, rxCnt, doneCnt, ln;
   int             urCnt, hdrCnt;

   crt_framer i_crt_framer (.clk(clk), .rst(rst), .nodeAddr(nodeAddr), .edcMode(edcMode),
      .preLen(preLen), .ipgCycles(ipgCycles), .txStart(txStart), .txHdr(txHdr),
      .txPayLen(txPayLen), .txPayData(txPayData), .txPayValid(txPayValid),
      .txPayReady(txPayReady), .txBusy(txBusy), .txUnderrun(txUnderrun),
      .phyTxValid(phyTxValid),
      .phyTxData(phyTxData), .phyRxValid(phyRxValid), .phyRxData(phyRxData), .rxHdr(rxHdr),
      .rxHdrValid(rxHdrValid), .rxPayData(rxPayData), .rxPayValid(rxPayValid),
      .rxDone(rxDone), .rxRes(rxRes));
   crt_peer_model i_crt_peer_model (.clk(clk), .phyTxValid(phyTxValid),
      .phyTxData(phyTxData), .phyRxValid(phyRxValid), .phyRxData(phyRxData));

   always #5 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard, far above the planned traffic
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         results();
      end
   end

   // payload feeder follows the ready strobe
   always @(posedge clk)
      if (txPayReady) begin
         pIdx <= pIdx + 1;
         txPayData <= pay[pIdx + 1];
      end

   // receive side monitor
   always @(posedge clk) begin
      if (txUnderrun) urCnt++;
      if (rxHdrValid) hdrCnt++;
      if (rxPayValid) begin
         check("rxPayData", rxPayData, i_crt_peer_model.rxBuf[4 + rxCnt]);
         rxCnt++;
      end
      if (rxDone) begin
         doneCnt++;
         resQ = rxRes;
      end
   end

   // one transmit frame against the byte list worked out here
   task automatic txFrame(input logic [31:0] h, input int len, input int pre, input crt_edc_t m);
      logic [7:0] e [$];
      logic [7:0] s, b;
      do @(negedge clk); while (txBusy !== 1'b0);
      i_crt_peer_model.txCap.delete();
      for (int k = 1; k < pre; k++) e.push_back(8'h55);
      e.push_back(8'hd5);
      s = 8'h00;
      for (int k = 0; k < 4 + len; k++) begin
         b = (k == 1) ? nodeAddr : (k < 4) ? h[31 - 8 * k -: 8] : pay[k - 4];
         s = i_crt_peer_model.edcStep(m, s, b);
         e.push_back(b);
      end
      if (m != EDC_NONE) e.push_back(s);
      @(posedge clk);
      edcMode <= m;
      preLen <= pre[3:0];
      txHdr <= h;
      txPayLen <= len[15:0];
      txStart <= 1'b1;
      pIdx <= 0;
      txPayData <= pay[0];
      @(posedge clk);
      txStart <= 1'b0;
      do @(negedge clk); while (txBusy !== 1'b0);
      check("txLength", i_crt_peer_model.txCap.size(), e.size());
      for (int k = 0; k < e.size() && k < i_crt_peer_model.txCap.size(); k++)
         check("txByte", i_crt_peer_model.txCap[k], e[k]);
   endtask

   // one receive frame with its expected result and delivered count
   task automatic rxFrame(input logic [31:0] h, input int len, input int pre, input crt_edc_t m,
                          input logic bad, input logic [4:0] er, input int ep);
      for (int k = 0; k < 4; k++) i_crt_peer_model.rxBuf[k] = h[31 - 8 * k -: 8];
      for (int k = 4; k < 4 + len; k++) i_crt_peer_model.rxBuf[k] = 8'($urandom);
      @(posedge clk);
      edcMode <= m;
      rxCnt = 0;
      doneCnt = 0;
      hdrCnt = 0;
      i_crt_peer_model.send(4 + len, pre, m, bad);
      for (int k = 0; k < 12 && doneCnt == 0; k++) @(negedge clk);
      check("rxDone", doneCnt, 1);
      check("rxHdrValid", hdrCnt, 1);
      check("rxRes", resQ, er);
      check("rxPayCount", rxCnt, ep);
      check("rxHdr", rxHdr, h);
   endtask

   initial begin
      void'($urandom(32'hc1272119));
      clk = 1'b0;
      rst = 1'b1;
      nodeAddr = 8'(2 + $urandom % 252);
      edcMode = EDC_CRC8;
      preLen = 4'h1;
      ipgCycles = IPG_MIN_CYC;
      txStart = 1'b0;
      txHdr = '0;
      txPayLen = 16'h0000;
      txPayData = 8'h00;
      txPayValid = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // transmit: every check mode, random preamble, empty payload first
      for (int i = 0; i < 6; i++) begin
         ln = (i == 0) ? 0 : 1 + $urandom % 5;
         for (int k = 0; k < ln; k++) pay[k] = (i == 5) ? 8'h00 : 8'($urandom);
         // the gap is read live, so after widening it the idle time is waited out once
         if (i == 4) begin
            @(posedge clk);
            ipgCycles <= 8'h28;
            repeat (40) @(posedge clk);
         end
         // last frame starves the payload: each payload byte goes out as 8'h00, with txUnderrun high for one cycle each
         if (i == 5) begin
            urCnt = 0;
            @(posedge clk);
            txPayValid <= 1'b0;
         end
         txFrame({8'($urandom), 8'hff, 8'($urandom % 10), 8'($urandom % 128)}, ln,
                 1 + $urandom % 8, crt_edc_t'(i % 3));
      end
      check("txGap", 32'(i_crt_peer_model.lastGap >= 40 + 2), 1);
      check("txUnderrun", urCnt, ln);
      // receive corner cases
      rxFrame({nodeAddr, 8'h05, 8'h06, 8'h31}, 3, 1, EDC_CRC8, 0, 5'h10, 3);
      rxFrame({8'hff, 8'h00, 8'h05, 8'h03}, 2, 8, EDC_LRC8, 0, 5'h10, 2);
      rxFrame({nodeAddr + 8'h01, 8'h00, 8'h02, 8'h23}, 2, 1, EDC_NONE, 0, 5'h00, 0);
      rxFrame({nodeAddr, 8'h00, 8'h01, 8'h13}, 0, 1, EDC_NONE, 0, 5'h10, 0);
      rxFrame({nodeAddr, 8'h00, 8'h09, 8'h62}, 0, 2, EDC_CRC8, 1, 5'h14, 0);
      rxFrame({nodeAddr, 8'hff, 8'h07, 8'h40}, 0, 1, EDC_CRC8, 0, 5'h12, 0);
      rxFrame({nodeAddr, 8'h00, 8'h0a, 8'h30}, 0, 1, EDC_CRC8, 0, 5'h11, 0);
      rxFrame({nodeAddr, 8'h00, 8'h03, 8'h80}, 0, 1, EDC_CRC8, 0, 5'h11, 0);
      rxFrame({nodeAddr, 8'h00, 8'h05, 8'h3f}, 1600, 1, EDC_CRC8, 0, 5'h10, 1600);
      // three header bytes only
      doneCnt = 0;
      hdrCnt = 0;
      i_crt_peer_model.send(3, 1, EDC_NONE, 0);
      for (int k = 0; k < 12 && doneCnt == 0; k++) @(negedge clk);
      check("rxShort", {31'h0, resQ.shortFrame}, 1);
      check("rxShortHdr", hdrCnt, 0);
      results();
   end
endmodule // test_compact_rt_ethernet_framer
